// [sfpi_map.svh]
`ifndef SFPI_MAP_SVH
`define SFPI_MAP_SVH

// ==========================================
// timing
`define SFPI_CLK_NS 50
`define SFPI_RESET_PULSE_MIN_NS 1000
`define SFPI_RESET_PULSE_CYC \
  ((`SFPI_RESET_PULSE_MIN_NS + `SFPI_CLK_NS - 1) / `SFPI_CLK_NS)

// ==========================================
// address masks
`define SFPI_ADDR_ALL 24'hFFFFFF
`define SFPI_WRAP_MIN_MASK 24'h000007
`define SFPI_PAGE_MASK 24'h0000FF
`define SFPI_SECTOR_MASK 24'h000FFF
`define SFPI_BLOCK32_MASK 24'h007FFF
`define SFPI_BLOCK64_MASK 24'h00FFFF

// ==========================================
// pin positions in the synchroniser word
`define SFPI_PIN_SCLK 5
`define SFPI_PIN_CS 4
`define SFPI_PIN_WP 2
`define SFPI_PIN_D3 3

`endif

// [sfpi_pkg.sv]
package sfpi_pkg;

  typedef enum logic [1:0] {
    LK_IDLE   = 2'h0,
    LK_SEL    = 2'h1,
    LK_PAUSED = 2'h3,
    LK_RESET  = 2'h2
  } sfpi_link_t;

  typedef enum logic [1:0] {
    LN_ONE  = 2'h0,
    LN_TWO  = 2'h1,
    LN_FOUR = 2'h2
  } sfpi_lanes_t;

  typedef enum logic [2:0] {
    PH_INSTR = 3'h0,
    PH_ADDR0 = 3'h1,
    PH_ADDR1 = 3'h3,
    PH_ADDR2 = 3'h2,
    PH_DATA  = 3'h6
  } sfpi_phase_t;

  typedef enum logic [1:0] {
    ER_SECTOR  = 2'h0,
    ER_BLOCK32 = 2'h1,
    ER_BLOCK64 = 2'h2
  } sfpi_erase_t;

endpackage

// [sfpi_sync.sv]
`timescale 1ns/1ps
module sfpi_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;
endmodule

// [sfpi_top.sv]
`timescale 1ns/1ps
`include "sfpi_map.svh"
module sfpi_top (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // link pins
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic [3:0] DQ_I,
  output logic [3:0] DQ_O,
  output logic [3:0] DQ_OE_O,
  // configuration bits
  input wire logic QUAD_ENABLE_BIT_I,
  input wire logic PAUSE_OR_RESET_SELECT_I,
  input wire logic QUAD_INSTRUCTION_MODE_I,
  input wire logic STATUS_PROTECT_BIT0_I,
  input wire logic CONT_READ_I,
  input wire logic WRAP_EN_I,
  input wire logic [1:0] WRAP_SEL_I,
  input wire logic [1:0] ERASE_SEL_I,
  // command core side
  input wire logic [1:0] LANES_I,
  input wire logic TX_EN_I,
  input wire logic [7:0] TX_BYTE_I,
  input wire logic [7:0] PROG_OLD_I,
  output logic RX_VALID_O,
  output logic [7:0] RX_BYTE_O,
  output logic RX_IS_INSTR_O,
  output logic TX_LOAD_O,
  output logic ADDR_VALID_O,
  output logic [23:0] ADDR_O,
  output logic [23:0] ERASE_BASE_O,
  output logic [7:0] PROG_BYTE_O,
  // link status
  output logic SELECTED_O,
  output logic PAUSED_O,
  output logic HW_RESET_O,
  output logic STATUS_WRITE_BLOCK_O
);
  localparam logic [4:0] RST_CYC = 5'(`SFPI_RESET_PULSE_CYC);

  // ==========================================
  // pin synchronisers
  logic [5:0] pin_s;
  logic sclk_s;
  logic cs_s;
  logic [3:0] d_s;

  sfpi_sync #(.WIDTH(6)) u_sync (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .d_i({SCLK_I, CS_N_I, DQ_I}),
    .q_o(pin_s)
  );

  assign sclk_s = pin_s[`SFPI_PIN_SCLK];
  assign cs_s = pin_s[`SFPI_PIN_CS];
  assign d_s = pin_s[3:0];

  // ==========================================
  // state
  sfpi_pkg::sfpi_link_t st_q, st_d;
  sfpi_pkg::sfpi_phase_t ph_q, ph_d, ph_nx;
  sfpi_pkg::sfpi_lanes_t lanes;
  logic sclk_prev_q, sclk_prev_d;
  logic seen_q, seen_d;
  logic [4:0] low_q, low_d;
  logic [2:0] cnt_q, cnt_d;
  logic [2:0] step;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic [7:0] tx_sh_q, tx_sh_d;
  logic [7:0] nsh;
  logic [7:0] src;
  logic [3:0] dq_q, dq_d;
  logic [3:0] oe_q, oe_d;
  logic [23:0] addr_q, addr_d;
  logic [23:0] wmask;
  logic [23:0] emask;
  logic [23:0] erase_q, erase_d;
  logic [7:0] rx_byte_q, rx_byte_d;
  logic [7:0] prog_q, prog_d;
  logic rx_valid_q, rx_valid_d;
  logic instr_q, instr_d;
  logic tx_load_q, tx_load_d;
  logic addr_valid_q, addr_valid_d;
  logic sel_q, sel_d;
  logic paused_q, paused_d;
  logic hwrst_q, hwrst_d;
  logic block_q, block_d;
  logic sclk_rise;
  logic sclk_fall;
  logic pause_en;
  logic rst_en;
  logic pin3_low;

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign pause_en = ~QUAD_ENABLE_BIT_I & ~PAUSE_OR_RESET_SELECT_I;
  assign rst_en = ~QUAD_ENABLE_BIT_I & PAUSE_OR_RESET_SELECT_I;
  assign pin3_low = ~d_s[`SFPI_PIN_D3];

  // stays inside the aligned window given by mask m
  function automatic logic [23:0] wrap_inc(input logic [23:0] a, input logic [23:0] m);
    wrap_inc = (a & ~m) | ((a + 24'h000001) & m);
  endfunction

  // ==========================================
  // next-state logic
  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    cnt_d = cnt_q;
    rx_sh_d = rx_sh_q;
    tx_sh_d = tx_sh_q;
    dq_d = dq_q;
    addr_d = addr_q;
    rx_byte_d = rx_byte_q;
    prog_d = prog_q;
    instr_d = instr_q;
    rx_valid_d = 1'b0;
    tx_load_d = 1'b0;
    addr_valid_d = 1'b0;
    nsh = rx_sh_q;
    src = tx_sh_q;
    sclk_prev_d = sclk_s;
    seen_d = seen_q | cs_s;
    // quad lanes need quad enable unless in quad-instruction mode
    if (QUAD_INSTRUCTION_MODE_I) begin
      lanes = sfpi_pkg::LN_FOUR;
    end else if (LANES_I == sfpi_pkg::LN_FOUR && !QUAD_ENABLE_BIT_I) begin
      lanes = sfpi_pkg::LN_ONE;
    end else if (LANES_I == sfpi_pkg::LN_FOUR || LANES_I == sfpi_pkg::LN_TWO) begin
      lanes = sfpi_pkg::sfpi_lanes_t'(LANES_I);
    end else begin
      lanes = sfpi_pkg::LN_ONE;
    end
    step = 3'h1 << lanes;
    case (ph_q)
      sfpi_pkg::PH_INSTR: ph_nx = sfpi_pkg::PH_ADDR0;
      sfpi_pkg::PH_ADDR0: ph_nx = sfpi_pkg::PH_ADDR1;
      sfpi_pkg::PH_ADDR1: ph_nx = sfpi_pkg::PH_ADDR2;
      default: ph_nx = sfpi_pkg::PH_DATA;
    endcase
    wmask = WRAP_EN_I ? ((`SFPI_WRAP_MIN_MASK << WRAP_SEL_I) | `SFPI_WRAP_MIN_MASK)
                      : `SFPI_ADDR_ALL;
    if (rst_en && pin3_low) begin
      low_d = (low_q == RST_CYC) ? low_q : 5'(low_q + 5'h01);
    end else begin
      low_d = 5'h00;
    end
    case (st_q)
      sfpi_pkg::LK_IDLE: begin
        // a low select without an earlier high sample is not a select edge
        if (seen_q && !cs_s) begin
          st_d = sfpi_pkg::LK_SEL;
          cnt_d = 3'h0;
          ph_d = CONT_READ_I ? sfpi_pkg::PH_ADDR0 : sfpi_pkg::PH_INSTR;
        end
      end
      sfpi_pkg::LK_SEL: begin
        if (cs_s) begin
          st_d = sfpi_pkg::LK_IDLE;
        end else if (pause_en && pin3_low) begin
          st_d = sfpi_pkg::LK_PAUSED;
        end else begin
          if (sclk_rise) begin
            cnt_d = 3'(cnt_q + step);
            if (!TX_EN_I) begin
              case (lanes)
                sfpi_pkg::LN_FOUR: nsh = {rx_sh_q[3:0], d_s};
                sfpi_pkg::LN_TWO: nsh = {rx_sh_q[5:0], d_s[1:0]};
                default: nsh = {rx_sh_q[6:0], d_s[0]};
              endcase
              rx_sh_d = nsh;
              if (cnt_d == 3'h0) begin
                rx_valid_d = 1'b1;
                rx_byte_d = nsh;
                instr_d = (ph_q == sfpi_pkg::PH_INSTR);
                ph_d = ph_nx;
                addr_valid_d = (ph_q == sfpi_pkg::PH_ADDR2);
                if (ph_q == sfpi_pkg::PH_DATA) begin
                  prog_d = nsh & PROG_OLD_I;
                  addr_d = wrap_inc(addr_q, `SFPI_PAGE_MASK);
                end else if (ph_q != sfpi_pkg::PH_INSTR) begin
                  addr_d = {addr_q[15:0], nsh};
                end
              end
            end
          end
          if (sclk_fall && TX_EN_I) begin
            src = (cnt_q == 3'h0) ? TX_BYTE_I : tx_sh_q;
            if (cnt_q == 3'h0) begin
              tx_load_d = 1'b1;
              if (ph_q == sfpi_pkg::PH_DATA) begin
                addr_d = wrap_inc(addr_q, wmask);
              end
            end
            case (lanes)
              sfpi_pkg::LN_FOUR: begin
                dq_d = src[7:4];
                tx_sh_d = {src[3:0], 4'h0};
              end
              sfpi_pkg::LN_TWO: begin
                dq_d = {2'h0, src[7:6]};
                tx_sh_d = {src[5:0], 2'h0};
              end
              default: begin
                dq_d = {2'h0, src[7], 1'b0};
                tx_sh_d = {src[6:0], 1'b0};
              end
            endcase
          end
        end
      end
      sfpi_pkg::LK_PAUSED: begin
        // shift, count and phase are left alone here
        if (cs_s) begin
          st_d = sfpi_pkg::LK_IDLE;
        end else if (!(pause_en && pin3_low)) begin
          st_d = sfpi_pkg::LK_SEL;
        end
      end
      sfpi_pkg::LK_RESET: begin
        if (!(rst_en && pin3_low)) begin
          st_d = sfpi_pkg::LK_IDLE;
        end
      end
      default: st_d = sfpi_pkg::LK_IDLE;
    endcase
    // reset pin wins over everything else on the link
    if (st_q != sfpi_pkg::LK_RESET && rst_en && pin3_low && low_q == RST_CYC - 5'h01) begin
      st_d = sfpi_pkg::LK_RESET;
      ph_d = sfpi_pkg::PH_INSTR;
      cnt_d = 3'h0;
      rx_sh_d = 8'h00;
      tx_sh_d = 8'h00;
      seen_d = 1'b0;
    end
    if (st_d == sfpi_pkg::LK_SEL && TX_EN_I) begin
      case (lanes)
        sfpi_pkg::LN_FOUR: oe_d = 4'hF;
        sfpi_pkg::LN_TWO: oe_d = 4'h3;
        default: oe_d = 4'h2;
      endcase
    end else begin
      oe_d = 4'h0;
    end
    case (sfpi_pkg::sfpi_erase_t'(ERASE_SEL_I))
      sfpi_pkg::ER_BLOCK32: emask = `SFPI_BLOCK32_MASK;
      sfpi_pkg::ER_BLOCK64: emask = `SFPI_BLOCK64_MASK;
      default: emask = `SFPI_SECTOR_MASK;
    endcase
    erase_d = addr_q & ~emask;
    sel_d = (st_d == sfpi_pkg::LK_SEL) || (st_d == sfpi_pkg::LK_PAUSED);
    paused_d = (st_d == sfpi_pkg::LK_PAUSED);
    hwrst_d = (st_d == sfpi_pkg::LK_RESET);
    // protect pin only counts while quad enable is clear, even when quad-instruction mode makes line 2 a data line
    block_d = STATUS_PROTECT_BIT0_I & ~d_s[`SFPI_PIN_WP] & ~QUAD_ENABLE_BIT_I;
  end

  // ==========================================
  // registers
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= sfpi_pkg::LK_IDLE;
      ph_q <= sfpi_pkg::PH_INSTR;
      sclk_prev_q <= 1'b0;
      seen_q <= 1'b0;
      low_q <= 5'h00;
      cnt_q <= 3'h0;
      rx_sh_q <= 8'h00;
      tx_sh_q <= 8'h00;
      dq_q <= 4'h0;
      oe_q <= 4'h0;
      addr_q <= 24'h000000;
      erase_q <= 24'h000000;
      rx_byte_q <= 8'h00;
      prog_q <= 8'h00;
      rx_valid_q <= 1'b0;
      instr_q <= 1'b0;
      tx_load_q <= 1'b0;
      addr_valid_q <= 1'b0;
      sel_q <= 1'b0;
      paused_q <= 1'b0;
      hwrst_q <= 1'b0;
      block_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      sclk_prev_q <= sclk_prev_d;
      seen_q <= seen_d;
      low_q <= low_d;
      cnt_q <= cnt_d;
      rx_sh_q <= rx_sh_d;
      tx_sh_q <= tx_sh_d;
      dq_q <= dq_d;
      oe_q <= oe_d;
      addr_q <= addr_d;
      erase_q <= erase_d;
      rx_byte_q <= rx_byte_d;
      prog_q <= prog_d;
      rx_valid_q <= rx_valid_d;
      instr_q <= instr_d;
      tx_load_q <= tx_load_d;
      addr_valid_q <= addr_valid_d;
      sel_q <= sel_d;
      paused_q <= paused_d;
      hwrst_q <= hwrst_d;
      block_q <= block_d;
    end
  end

  assign DQ_O = dq_q;
  assign DQ_OE_O = oe_q;
  assign RX_VALID_O = rx_valid_q;
  assign RX_BYTE_O = rx_byte_q;
  assign RX_IS_INSTR_O = instr_q;
  assign TX_LOAD_O = tx_load_q;
  assign ADDR_VALID_O = addr_valid_q;
  assign ADDR_O = addr_q;
  assign ERASE_BASE_O = erase_q;
  assign PROG_BYTE_O = prog_q;
  assign SELECTED_O = sel_q;
  assign PAUSED_O = paused_q;
  assign HW_RESET_O = hwrst_q;
  assign STATUS_WRITE_BLOCK_O = block_q;

  // ==========================================
  // assertions
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  a_deselect_float: assert property (cs_s |=> oe_q == 4'h0)
    else $error("data lines driven while deselected");
  a_no_first_select: assert property (!seen_q |=> st_q != sfpi_pkg::LK_SEL)
    else $error("selected without prior high select");
  a_pause_float: assert property (st_q == sfpi_pkg::LK_PAUSED |-> oe_q == 4'h0)
    else $error("output driven during pause");
  a_pause_holds_count: assert property (st_q == sfpi_pkg::LK_PAUSED |=>
    (st_q == sfpi_pkg::LK_RESET || ($stable(cnt_q) && $stable(rx_sh_q))))
    else $error("shift state moved during pause");
  a_reset_after_low: assert property ((st_q != sfpi_pkg::LK_RESET && rst_en && pin3_low
    && low_q == RST_CYC - 5'h01) |=> st_q == sfpi_pkg::LK_RESET && hwrst_q)
    else $error("reset pin held long enough but no reset");
  a_reset_not_early: assert property ((st_q != sfpi_pkg::LK_RESET
    && low_q < RST_CYC - 5'h01) |=> st_q != sfpi_pkg::LK_RESET)
    else $error("reset taken before the minimum pulse");
  a_quad_no_pause: assert property (QUAD_ENABLE_BIT_I |=>
    st_q != sfpi_pkg::LK_PAUSED && st_q != sfpi_pkg::LK_RESET)
    else $error("pin 3 used as control while quad enabled");
  a_wp_block: assert property ($rose(block_q) |->
    $past(STATUS_PROTECT_BIT0_I) && !$past(QUAD_ENABLE_BIT_I))
    else $error("status write blocked without protect conditions");
  a_out_on_fall: assert property (!sclk_fall |=> $stable(dq_q))
    else $error("output data changed off a falling edge");
  a_rx_on_rise: assert property (rx_valid_q |-> $past(sclk_rise))
    else $error("byte completed without a rising edge");
  a_quad_lines: assert property (oe_q[3:2] != 2'h0 |->
    $past(QUAD_ENABLE_BIT_I) || $past(QUAD_INSTRUCTION_MODE_I))
    else $error("lines 2 and 3 driven outside quad");
endmodule

// [sfpi_host.sv]
`timescale 1ns/1ps
module sfpi_host (
  // system clock
  input wire logic mclk_i,
  // device side of the data lines
  input wire logic [3:0] dev_dq_i,
  input wire logic [3:0] dev_oe_i,
  // link pins towards the device
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] dq_o
);
  logic [3:0] drv = 4'h0;
  logic [3:0] val = 4'h0;
  logic [3:0] last_q = 4'h0;
  logic wp = 1'b1;
  logic p3 = 1'b1;
  logic q4 = 1'b0;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
  end

  // ==========================================
  // wire level
  // an undriven line toggles so stale data can never pass as a match, except lines 2 and 3, which hold wp and p3 while q4 is clear
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (dev_oe_i[k]) dq_o[k] = dev_dq_i[k];
      else if (drv[k]) dq_o[k] = val[k];
      else if (k == 2 && !q4) dq_o[k] = wp;
      else if (k == 3 && !q4) dq_o[k] = p3;
      else dq_o[k] = ~last_q[k];
    end
  end

  always @(posedge mclk_i) last_q <= dq_o;

  // ==========================================
  // link cycles, entered at a falling system clock edge
  task automatic xfer(input logic [7:0] tx, input int lanes, input bit rd, input int units,
                      output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    for (int u = 0; u < units; u++) begin
      sclk_o = 1'b0;
      drv = rd ? 4'h0 : (lanes == 4 ? 4'hF : (lanes == 2 ? 4'h3 : 4'h1));
      val = lanes == 4 ? sh[7:4] : (lanes == 2 ? {2'h0, sh[7:6]} : {3'h0, sh[7]});
      sh = sh << lanes;
      repeat (4) @(negedge mclk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge mclk_i);
      // sampled late in the high phase, clear of the synchroniser lag
      rx = (rx << lanes) | (lanes == 4 ? dq_o : (lanes == 2 ? dq_o[1:0] : dq_o[1]));
    end
  endtask

  task automatic sel();
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    repeat (6) @(negedge mclk_i);
    cs_n_o = 1'b0;
    repeat (6) @(negedge mclk_i);
  endtask

  task automatic desel();
    sclk_o = 1'b0;
    drv = 4'h0;
    repeat (4) @(negedge mclk_i);
    cs_n_o = 1'b1;
    repeat (6) @(negedge mclk_i);
  endtask
endmodule

// [sfpi_top_tb.sv]
`timescale 1ns/1ps
module sfpi_top_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs_n;
  logic [3:0] dq_in, dq_out, dq_oe;
  logic qe = 0, prs = 0, quad_instruction_mode = 0, sp = 0, cont = 0, wrap_en = 0, tx_en = 0;
  logic [1:0] wrap_sel = 0, erase_sel = 0, lanes = 0;
  logic [7:0] tx_byte = 0, prog_old = 0, rx_byte, prog_byte, rxd, b;
  logic rx_valid, rx_instr, tx_load, addr_valid, selected, paused, hw_reset, sw_block;
  logic [23:0] addr, erase_base, a, mk;
  int bad_count = 0, samples_checked = 0, loads = 0, ln, avs = 0;
  logic [8:0] exp_q[$];

  sfpi_top sfpi_top_i (.MCLK_I(mclk), .RST_N_I(rst_n), .SCLK_I(sclk), .CS_N_I(cs_n),
    .DQ_I(dq_in), .DQ_O(dq_out), .DQ_OE_O(dq_oe), .QUAD_ENABLE_BIT_I(qe),
    .PAUSE_OR_RESET_SELECT_I(prs), .QUAD_INSTRUCTION_MODE_I(quad_instruction_mode),
    .STATUS_PROTECT_BIT0_I(sp), .CONT_READ_I(cont), .WRAP_EN_I(wrap_en),
    .WRAP_SEL_I(wrap_sel), .ERASE_SEL_I(erase_sel), .LANES_I(lanes), .TX_EN_I(tx_en),
    .TX_BYTE_I(tx_byte), .PROG_OLD_I(prog_old), .RX_VALID_O(rx_valid), .RX_BYTE_O(rx_byte),
    .RX_IS_INSTR_O(rx_instr), .TX_LOAD_O(tx_load), .ADDR_VALID_O(addr_valid),
    .ADDR_O(addr), .ERASE_BASE_O(erase_base), .PROG_BYTE_O(prog_byte),
    .SELECTED_O(selected), .PAUSED_O(paused), .HW_RESET_O(hw_reset),
    .STATUS_WRITE_BLOCK_O(sw_block));

  sfpi_host sfpi_host_i (.mclk_i(mclk), .dev_dq_i(dq_out), .dev_oe_i(dq_oe), .sclk_o(sclk),
    .cs_n_o(cs_n), .dq_o(dq_in));

  initial begin
    forever #25 mclk = ~mclk;
  end

  // ==========================================
  // comparison and verdict
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // every received byte is matched against the model queue
  always @(negedge mclk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) check("rx surplus", 32'h1, 32'h0);
      else check("rx byte", {23'h0, rx_instr, rx_byte}, {23'h0, exp_q.pop_front()});
    end
    if (tx_load === 1'b1) loads++;
    if (addr_valid === 1'b1) avs++;
  end

  task automatic put(input logic [7:0] v, input int n, input bit instr);
    exp_q.push_back({instr, v});
    sfpi_host_i.xfer(v, n, 0, 8 / n, rxd);
  endtask

  task automatic put_addr(input logic [23:0] v);
    put(v[23:16], 1, 0);
    put(v[15:8], 1, 0);
    put(v[7:0], 1, 0);
  endtask

  // ==========================================
  // scenarios
  initial begin
    void'($urandom(39));
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    // select low since power-up is not a select
    sfpi_host_i.xfer(8'hA5, 1, 0, 8, rxd);
    check("selected", selected, 0);
    a = 24'($urandom()) | 24'h0000FF;
    prog_old = 8'($urandom());
    sfpi_host_i.sel();
    check("selected", selected, 1);
    put(8'($urandom()), 1, 1);
    put_addr(a);
    repeat (4) @(negedge mclk);
    check("addr", addr, a);
    b = 8'($urandom());
    put(b, 1, 0);
    repeat (4) @(negedge mclk);
    check("prog byte", prog_byte, b & prog_old);
    check("addr page", addr, {a[23:8], 8'h00});
    for (int e = 0; e < 4; e++) begin
      erase_sel = 2'(e);
      repeat (3) @(negedge mclk);
      check("erase base", erase_base, {a[23:8], 8'h00} &
        ~(e == 1 ? 24'h007FFF : (e == 2 ? 24'h00FFFF : 24'h000FFF)));
    end
    sfpi_host_i.desel();
    check("oe idle", dq_oe, 0);
    check("deselected", selected, 0);
    // single, dual, quad, quad code falling back to single, unused code as single
    for (int m = 0; m < 5; m++) begin
      ln = m == 2 ? 4 : (m == 1 ? 2 : 1);
      qe = m == 2;
      sfpi_host_i.q4 = qe;
      wrap_en = 1'b1;
      wrap_sel = 2'($urandom());
      a = 24'($urandom());
      mk = (24'h8 << wrap_sel) - 24'h1;
      sfpi_host_i.sel();
      put(8'($urandom()), 1, 1);
      put_addr(a);
      lanes = m == 3 ? 2'h2 : (m == 4 ? 2'h3 : 2'(m));
      tx_byte = 8'($urandom());
      tx_en = 1'b1;
      loads = 0;
      sfpi_host_i.xfer(8'h00, ln, 1, 8 / ln, rxd);
      check("read byte", rxd, tx_byte);
      check("oe lanes", dq_oe, m == 2 ? 4'hF : (m == 1 ? 4'h3 : 4'h2));
      check("loads", loads, 1);
      check("wrap addr", addr, (a & ~mk) | ((a + 1) & mk));
      tx_en = 1'b0;
      lanes = 2'h0;
      sfpi_host_i.desel();
      check("oe released", dq_oe, 0);
    end
    qe = 1'b0;
    sfpi_host_i.q4 = 1'b0;
    lanes = 2'h0;
    wrap_en = 1'b0;
    // pause in mid-byte, clocks during pause must not count
    b = 8'($urandom());
    exp_q.push_back({1'b1, b});
    sfpi_host_i.sel();
    sfpi_host_i.xfer(b, 1, 0, 4, rxd);
    sfpi_host_i.p3 = 1'b0;
    repeat (4) @(negedge mclk);
    check("paused", paused, 1);
    check("oe paused", dq_oe, 0);
    sfpi_host_i.xfer(8'h00, 1, 0, 2, rxd);
    sfpi_host_i.p3 = 1'b1;
    repeat (4) @(negedge mclk);
    check("resumed", paused, 0);
    sfpi_host_i.xfer(b << 4, 1, 0, 4, rxd);
    sfpi_host_i.desel();
    // quad enabled: pin 3 is data only
    qe = 1'b1;
    sfpi_host_i.q4 = 1'b1;
    sfpi_host_i.sel();
    sfpi_host_i.drv = 4'h8;
    sfpi_host_i.val = 4'h0;
    repeat (6) @(negedge mclk);
    check("no pause", paused, 0);
    prs = 1'b1;
    repeat (30) @(negedge mclk);
    check("no reset", hw_reset, 0);
    sfpi_host_i.desel();
    qe = 1'b0;
    sfpi_host_i.q4 = 1'b0;
    // hardware reset: short pulse ignored, long pulse aborts
    sfpi_host_i.sel();
    sfpi_host_i.xfer(8'($urandom()), 1, 0, 4, rxd);
    sfpi_host_i.p3 = 1'b0;
    repeat (10) @(negedge mclk);
    sfpi_host_i.p3 = 1'b1;
    check("short pulse", hw_reset, 0);
    repeat (4) @(negedge mclk);
    sfpi_host_i.p3 = 1'b0;
    repeat (26) @(negedge mclk);
    check("hw reset", hw_reset, 1);
    sfpi_host_i.p3 = 1'b1;
    repeat (4) @(negedge mclk);
    check("reset end", hw_reset, 0);
    sfpi_host_i.xfer(8'($urandom()), 1, 0, 8, rxd);
    sfpi_host_i.desel();
    prs = 1'b0;
    // status write block follows pin 2 only without quad enable
    sp = 1'b1;
    sfpi_host_i.wp = 1'b0;
    repeat (4) @(negedge mclk);
    check("sw block", sw_block, 1);
    qe = 1'b1;
    repeat (4) @(negedge mclk);
    check("sw block qe", sw_block, 0);
    qe = 1'b0;
    sfpi_host_i.wp = 1'b1;
    repeat (4) @(negedge mclk);
    check("sw block wp", sw_block, 0);
    sp = 1'b0;
    // four-lane instruction in two clocks
    quad_instruction_mode = 1'b1;
    qe = 1'b1;
    sfpi_host_i.q4 = 1'b1;
    sfpi_host_i.sel();
    put(8'($urandom()), 4, 1);
    sfpi_host_i.desel();
    quad_instruction_mode = 1'b0;
    qe = 1'b0;
    sfpi_host_i.q4 = 1'b0;
    // continuous read: address straight after select
    cont = 1'b1;
    a = 24'($urandom());
    sfpi_host_i.sel();
    avs = 0;
    put_addr(a);
    repeat (4) @(negedge mclk);
    check("cont addr", addr, a);
    check("addr valid", avs, 1);
    sfpi_host_i.desel();
    cont = 1'b0;
    check("rx missing", exp_q.size(), 0);
    results();
  end

  initial begin
    #1000000;
    bad_count++;
    results();
  end
endmodule
